// ---- rtl/faes_pkg.sv ----
// ---------------------------------------------------------------
// shared constants of the framer alarm and event status block
// ---------------------------------------------------------------
package faes_pkg;
	// register offsets on the 8-bit control port
	localparam logic [7:0] FAES_OFS_COND = 8'h1a;
	localparam logic [7:0] FAES_OFS_ALARM_GROUP3_IRQ_MASK = 8'h1b;
	localparam logic [7:0] FAES_OFS_SR4 = 8'h1c;
	localparam logic [7:0] FAES_OFS_FRAME_EVENT_IRQ_MASK = 8'h1d;
	// reset values
	localparam logic [7:0] FAES_RST_ALARM_GROUP3_IRQ_MASK = 8'h00;
	localparam logic [7:0] FAES_RST_SR4 = 8'h00;
	localparam logic [7:0] FAES_RST_FRAME_EVENT_IRQ_MASK = 8'h00;
	// bits 0..6 implemented in the fourth status and mask registers
	localparam logic [7:0] FAES_SR4_USED = 8'h7f;
	// condition bit positions
	localparam int FAES_B_RRA = 0;
	localparam int FAES_B_DMA = 1;
	localparam int FAES_B_LNK = 2;
	localparam int FAES_B_RCL = 3;
	localparam int FAES_B_TCL = 4;
	localparam int FAES_B_LUP = 5;
	localparam int FAES_B_LDN = 6;
	localparam int FAES_B_SPR = 7;
	// event bit positions
	localparam int FAES_E_RAF = 0;
	localparam int FAES_E_RX_CRC_MULTIFRAME_EVENT = 1;
	localparam int FAES_E_RMF = 2;
	localparam int FAES_E_TAF = 3;
	localparam int FAES_E_TMF = 4;
	localparam int FAES_E_SA0 = 5;
	localparam int FAES_E_SA1 = 6;
	// bit indices in a received octet, msb is bit 1 of the line
	localparam int FAES_DMA_IDX = 2; // ts16 bit 6
	localparam int FAES_RRA_IDX = 5; // non-align bit 3
	localparam int FAES_SA7_IDX = 1; // non-align bit 7
	// persistence counts and thresholds
	localparam int FAES_RRA_RUN = 3;
	localparam int FAES_DMA_RUN = 2;
	localparam logic [4:0] FAES_SA1_ZMAX = 5'd3;
	// frames per multiframe
	localparam logic [4:0] FAES_MF_E1 = 5'd16;
	localparam logic [4:0] FAES_MF_D4 = 5'd12;
	localparam logic [4:0] FAES_MF_ESF = 5'd24;
	// channel time, least time rounds up to whole clock cycles
	localparam int FAES_CLK_NS = 50;
	localparam int FAES_E1_CHAN_NS = 3906;
	localparam int FAES_T1_CHAN_NS = 5181;
	localparam logic [7:0] FAES_E1_CHAN_CYC = 8'((FAES_E1_CHAN_NS + FAES_CLK_NS - 1) / FAES_CLK_NS);
	localparam logic [7:0] FAES_T1_CHAN_CYC = 8'((FAES_T1_CHAN_NS + FAES_CLK_NS - 1) / FAES_CLK_NS);
endpackage : faes_pkg

// ---- rtl/faes_persist.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// state that flips after RUN consecutive samples of the other value
// ---------------------------------------------------------------
module faes_persist #(
	parameter int RUN = 3
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_strobe,
	input wire logic i_bit,
	output logic o_state
);
	import faes_pkg::*;
	localparam int CW = $clog2(RUN + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic state;
	} faes_per_t;
	faes_per_t st_r, st_nxt;

	// a run of opposite samples flips the state, a matching one restarts it
	always_comb begin
		st_nxt = st_r;
		if (i_strobe) begin
			if (i_bit != st_r.state) begin
				if (st_r.cnt == CW'(RUN - 1)) begin
					st_nxt.state = i_bit;
					st_nxt.cnt = '0;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end else begin
				st_nxt.cnt = '0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_state = st_r.state;

	a_flip_on_strobe: assert property (@(posedge i_core_clk) disable iff (i_srst)
		!$stable(st_r.state) |-> $past(i_strobe) && $past(i_ce))
		else $error("persist state moved without a sample");
endmodule // faes_persist

// ---- rtl/faes_core.sv ----
`timescale 1ns/1ps
// Behaviour
// - e1: distant mf alarm when ts16 frame0 bit 6 set two multiframes running
// - e1: access link detected flag follows recognised v5.2 link signal
// - receive clock loss set when line receive clock idle one channel time
// - transmit clock loss likewise; drives shared alarm pin when selected
// - t1: loop up, down and spare flags held while code received
// - group three mask: 0 blocks, 1 interrupts on both condition edges
// - e1: rx align frame event every 250us at align frame start
// - e1: rx crc4 multiframe event on boundary, free 2ms when crc4 off
// - e1: rx multiframe event every 2ms on rx multiframe boundary
// - t1: rx and tx multiframe events every 1.5ms d4 or 3ms esf
// - e1: tx align frame event every 250us at align frame start
// - e1: tx multiframe event every 2ms on tx multiframe boundary
// - e1: signaling all zeros event when ts16 zero over full multiframe
// - e1: signaling all ones event when ts16 under three zeros in 16 frames
// - group four mask: 0 masks event, 1 lets it interrupt
// - e1: remote alarm set after three ones, cleared after three zeros
// - latched event bits stay set until their status register is read
module faes_core (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// mode
	input wire logic i_e1_mode,
	input wire logic i_esf_mode,
	input wire logic i_crc4_en,
	input wire logic i_alarm_pin_sel,
	// framer timing and data
	input wire logic i_rx_frame_strobe,
	input wire logic i_rx_mf_start,
	input wire logic i_rx_crc_mf_start,
	input wire logic [7:0] i_ts16_data,
	input wire logic [7:0] i_rx_nonalign_bits,
	input wire logic i_tx_frame_strobe,
	input wire logic i_tx_mf_start,
	input wire logic i_rx_sync_loss,
	// line clocks, sampled as plain inputs
	input wire logic i_line_receive_clock_in,
	input wire logic i_line_transmit_clock,
	// in-band code detector matches
	input wire logic i_loop_up_match,
	input wire logic i_loop_down_match,
	input wire logic i_spare_match,
	output logic o_alarm_pin,
	output logic o_int_n
);
	import faes_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] alarm_group3_irq_mask;
		logic [7:0] frame_event_irq_mask;
		logic [7:0] sr4;
		logic [7:0] cond;
		logic [7:0] pend3;
		logic [7:0] rdata;
		logic int_n;
		logic alarm;
		logic [4:0] rx_fn;
		logic [4:0] rx_crc_fn;
		logic [4:0] tx_fn;
		logic zacc;
		logic [4:0] zcnt;
		logic dma_seen;
		logic [2:0] sa7_hist;
		logic lnk;
		logic rclk_d;
		logic line_transmit_clock_d;
		logic [7:0] rclk_idle;
		logic [7:0] line_transmit_clock_idle;
	} faes_state_t;
	faes_state_t st_r, st_nxt;

	logic rra_state;
	logic dma_state;
	logic naf_strobe;
	logic dma_strobe;
	logic [4:0] mf_len;
	logic [7:0] chan_cyc;
	logic [3:0] ts16_zeros;

	// non-align frames are the odd frames of the e1 multiframe
	assign naf_strobe = i_e1_mode && i_rx_frame_strobe && st_nxt.rx_fn[0];
	assign dma_strobe = i_e1_mode && i_rx_frame_strobe && (st_nxt.rx_fn == 5'd0);
	assign mf_len = i_e1_mode ? FAES_MF_E1 : (i_esf_mode ? FAES_MF_ESF : FAES_MF_D4);
	assign chan_cyc = i_e1_mode ? FAES_E1_CHAN_CYC : FAES_T1_CHAN_CYC;

	// zeros in the current ts16 octet
	always_comb begin
		ts16_zeros = '0;
		for (int i = 0; i < 8; i++) begin
			ts16_zeros = ts16_zeros + 4'(!i_ts16_data[i]);
		end
	end

	// ---------------------------------------------------------------
	// persistence filters
	// ---------------------------------------------------------------
	faes_persist #(.RUN(FAES_RRA_RUN)) u_rra (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_strobe(naf_strobe),
		.i_bit(i_rx_nonalign_bits[FAES_RRA_IDX]),
		.o_state(rra_state)
	);

	faes_persist #(.RUN(FAES_DMA_RUN)) u_dma (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_strobe(dma_strobe),
		.i_bit(i_ts16_data[FAES_DMA_IDX]),
		.o_state(dma_state)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [7:0] ev;
		logic [7:0] cond_new;
		logic [7:0] clr3;
		logic [7:0] clr4;
		logic rx_mf_end;
		logic [4:0] zsum;
		ev = '0;
		cond_new = '0;
		clr3 = '0;
		clr4 = '0;
		rx_mf_end = 1'b0;
		zsum = '0;
		st_nxt = st_r;

		// rx frame position; the framer's alignment marker restarts it
		if (i_rx_frame_strobe) begin
			rx_mf_end = (st_r.rx_fn == mf_len - 5'd1);
			if (i_rx_mf_start || rx_mf_end) begin
				st_nxt.rx_fn = '0;
			end else begin
				st_nxt.rx_fn = st_r.rx_fn + 5'd1;
			end
			if (i_e1_mode && !st_nxt.rx_fn[0]) begin
				ev[FAES_E_RAF] = 1'b1;
			end
			if (st_nxt.rx_fn == 5'd0) begin
				ev[FAES_E_RMF] = 1'b1;
			end
			// free running crc4 count keeps the event alive when crc4 is off
			if (i_crc4_en && i_rx_crc_mf_start) begin
				st_nxt.rx_crc_fn = '0;
			end else if (st_r.rx_crc_fn == FAES_MF_E1 - 5'd1) begin
				st_nxt.rx_crc_fn = '0;
			end else begin
				st_nxt.rx_crc_fn = st_r.rx_crc_fn + 5'd1;
			end
			if (i_e1_mode && st_nxt.rx_crc_fn == 5'd0) begin
				ev[FAES_E_RX_CRC_MULTIFRAME_EVENT] = 1'b1;
			end
		end

		// ts16 content over the multiframe, judged at its last frame; the zero count
		// saturates so a silent timeslot cannot wrap it back under the threshold
		if (i_rx_frame_strobe && i_e1_mode) begin
			zsum = (st_nxt.rx_fn == 5'd0) ? 5'(ts16_zeros) : st_r.zcnt + 5'(ts16_zeros);
			if (st_nxt.rx_fn == 5'd0) begin
				st_nxt.zacc = |i_ts16_data;
			end else begin
				st_nxt.zacc = st_r.zacc | (|i_ts16_data);
			end
			st_nxt.zcnt = (zsum > FAES_SA1_ZMAX) ? FAES_SA1_ZMAX : zsum;
			if (st_nxt.rx_fn == mf_len - 5'd1) begin
				ev[FAES_E_SA0] = !(st_r.zacc | (|i_ts16_data));
				ev[FAES_E_SA1] = zsum < FAES_SA1_ZMAX;
			end
		end

		// tx frame position
		if (i_tx_frame_strobe) begin
			if (i_tx_mf_start || st_r.tx_fn == mf_len - 5'd1) begin
				st_nxt.tx_fn = '0;
			end else begin
				st_nxt.tx_fn = st_r.tx_fn + 5'd1;
			end
			if (i_e1_mode && !st_nxt.tx_fn[0]) begin
				ev[FAES_E_TAF] = 1'b1;
			end
			if (st_nxt.tx_fn == 5'd0) begin
				ev[FAES_E_TMF] = 1'b1;
			end
		end

		// v5.2 link: two of the last three sa7 bits zero
		// non-align test spelled out here so st_nxt never loops through naf_strobe
		if (i_e1_mode && i_rx_frame_strobe && st_nxt.rx_fn[0]) begin
			st_nxt.sa7_hist = {st_r.sa7_hist[1:0], i_rx_nonalign_bits[FAES_SA7_IDX]};
			st_nxt.lnk = (st_nxt.sa7_hist == 3'b000) || (st_nxt.sa7_hist == 3'b001) ||
				(st_nxt.sa7_hist == 3'b010) || (st_nxt.sa7_hist == 3'b100);
		end

		// idle counters on the line clocks saturate at the channel time
		st_nxt.rclk_d = i_line_receive_clock_in;
		st_nxt.line_transmit_clock_d = i_line_transmit_clock;
		if (i_line_receive_clock_in != st_r.rclk_d) begin
			st_nxt.rclk_idle = '0;
		end else if (st_r.rclk_idle < chan_cyc) begin
			st_nxt.rclk_idle = st_r.rclk_idle + 8'd1;
		end
		if (i_line_transmit_clock != st_r.line_transmit_clock_d) begin
			st_nxt.line_transmit_clock_idle = '0;
		end else if (st_r.line_transmit_clock_idle < chan_cyc) begin
			st_nxt.line_transmit_clock_idle = st_r.line_transmit_clock_idle + 8'd1;
		end

		// real time conditions, e1-only and t1-only ones gated by mode
		cond_new[FAES_B_RRA] = i_e1_mode && rra_state;
		cond_new[FAES_B_DMA] = i_e1_mode && dma_state;
		cond_new[FAES_B_LNK] = i_e1_mode && st_r.lnk;
		cond_new[FAES_B_RCL] = st_r.rclk_idle >= chan_cyc;
		cond_new[FAES_B_TCL] = st_r.line_transmit_clock_idle >= chan_cyc;
		cond_new[FAES_B_LUP] = !i_e1_mode && i_loop_up_match;
		cond_new[FAES_B_LDN] = !i_e1_mode && i_loop_down_match;
		cond_new[FAES_B_SPR] = !i_e1_mode && i_spare_match;
		st_nxt.cond = cond_new;

		// register reads clear latched bits; a new edge or event wins
		if (i_rd && i_addr == FAES_OFS_COND) begin
			clr3 = 8'hff;
		end
		if (i_rd && i_addr == FAES_OFS_SR4) begin
			clr4 = 8'hff;
		end
		st_nxt.pend3 = (st_r.pend3 & ~clr3) | (cond_new ^ st_r.cond);
		st_nxt.sr4 = ((st_r.sr4 & ~clr4) | ev) & FAES_SR4_USED;

		// mask writes
		if (i_wr && i_addr == FAES_OFS_ALARM_GROUP3_IRQ_MASK) begin
			st_nxt.alarm_group3_irq_mask = i_wdata;
		end
		if (i_wr && i_addr == FAES_OFS_FRAME_EVENT_IRQ_MASK) begin
			st_nxt.frame_event_irq_mask = i_wdata & FAES_SR4_USED;
		end

		// read data register; unmapped addresses read zero
		if (i_rd) begin
			unique case (i_addr)
				FAES_OFS_COND: st_nxt.rdata = st_r.cond;
				FAES_OFS_ALARM_GROUP3_IRQ_MASK: st_nxt.rdata = st_r.alarm_group3_irq_mask;
				FAES_OFS_SR4: st_nxt.rdata = st_r.sr4;
				FAES_OFS_FRAME_EVENT_IRQ_MASK: st_nxt.rdata = st_r.frame_event_irq_mask;
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// interrupt from the registered pending bits, one cycle behind them
		st_nxt.int_n = !(|(st_r.pend3 & st_r.alarm_group3_irq_mask) || |(st_r.sr4 & st_r.frame_event_irq_mask));
		st_nxt.alarm = i_alarm_pin_sel ? st_r.cond[FAES_B_TCL] : i_rx_sync_loss;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_r <= '0;
			st_r.alarm_group3_irq_mask <= FAES_RST_ALARM_GROUP3_IRQ_MASK;
			st_r.frame_event_irq_mask <= FAES_RST_FRAME_EVENT_IRQ_MASK;
			st_r.sr4 <= FAES_RST_SR4;
			st_r.int_n <= 1'b1;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata = st_r.rdata;
	assign o_int_n = st_r.int_n;
	assign o_alarm_pin = st_r.alarm;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_sr4_read;
		i_ce && i_rd && i_addr == FAES_OFS_SR4;
	endsequence

	sequence s_no_event;
		!i_rx_frame_strobe && !i_tx_frame_strobe;
	endsequence

	a_sr4_read_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
		s_sr4_read and s_no_event |=> st_r.sr4 == 8'h00)
		else $error("event bits survived a status read");

	a_sr4_sticky: assert property (@(posedge i_core_clk) disable iff (i_srst)
		(st_r.sr4 != 8'h00) && !(i_rd && i_addr == FAES_OFS_SR4) |=> (st_r.sr4 & $past(st_r.sr4)) == $past(st_r.sr4))
		else $error("event bit dropped without a read");

	a_bit7_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
		!st_r.sr4[7] && !st_r.frame_event_irq_mask[7])
		else $error("unused bit 7 set");

	a_int_follows: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce |=> o_int_n == !(|($past(st_r.pend3) & $past(st_r.alarm_group3_irq_mask)) || |($past(st_r.sr4) & $past(st_r.frame_event_irq_mask))))
		else $error("interrupt output disagrees with pending bits");

	a_edge_pend: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && $changed(st_r.cond) |-> st_r.pend3 != 8'h00)
		else $error("condition edge not latched");

	a_rclk_loss: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && st_r.rclk_idle >= chan_cyc |=> !i_ce || st_r.cond[FAES_B_RCL])
		else $error("receive clock loss missed");

	a_rx_align_ev: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && i_e1_mode && i_rx_frame_strobe && !i_rx_mf_start && !st_r.rx_fn[0] |=>
		st_r.sr4[FAES_E_RAF] == ($past(st_r.sr4[FAES_E_RAF]) && !$past(i_rd && i_addr == FAES_OFS_SR4)))
		else $error("align frame event on wrong frame");

	a_rx_align_set: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && i_e1_mode && i_rx_frame_strobe && st_r.rx_fn[0] |=> st_r.sr4[FAES_E_RAF])
		else $error("align frame event missed");

	a_zeros_event: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && i_e1_mode && i_rx_frame_strobe && !i_rx_mf_start && st_r.rx_fn == 5'd14 && !st_r.zacc &&
		i_ts16_data == 8'h00 |=> st_r.sr4[FAES_E_SA0])
		else $error("signaling all zeros event missed");

	a_t1_no_e1_cond: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && !i_e1_mode |=> $past(i_e1_mode) || (st_r.cond[2:0] == 3'b000))
		else $error("e1 condition active in t1 mode");

	a_alarm_pin: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && i_alarm_pin_sel |=> o_alarm_pin == $past(st_r.cond[FAES_B_TCL]))
		else $error("shared alarm pin not following transmit clock loss");

	a_loop_code: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_ce && !i_e1_mode && i_loop_up_match |=> st_r.cond[FAES_B_LUP])
		else $error("loop up code not reported");
endmodule // faes_core

// ---- tb/faes_host.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host processor on the register port
// ---------------------------------------------------------------
module faes_host (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic [7:0] o_wdata
);
	// idle port from time zero
	initial begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
	// one write strobe, taken at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		#2;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_core_clk);
		#2;
		o_wr = 1'b0;
		o_wdata = ~d; // stale data must not look valid
	endtask
	// read strobe for one edge; data held until next read, so sample one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		#2;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_core_clk);
		#2;
		o_rd = 1'b0;
		@(posedge i_core_clk);
		#2;
		d = i_rdata;
	endtask
endmodule // faes_host

// ---- tb/faes_core_tb.sv ----
`timescale 1ns/1ps
module faes_core_tb;
	import faes_pkg::*;
	logic clk, srst, rd, wr, e1, esf, crc4, psel, rxs, rxm, rxc, txs, txm, sync_loss, rck, tck;
	logic loop_up_code_seen, loop_down_code_seen, spr, alarm, int_n, rck_en, tck_en, ce;
	logic [7:0] addr, wdata, rdata, ts, na, v;
	int fail_count, n_compared, fn;
	// ---------------------------------------------------------------
	// clock, line clocks, design and host
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// line clocks toggle off the sampling edge; gating them models a lost clock
	always begin
		@(posedge clk);
		#2;
		if (rck_en) rck = ~rck;
		if (tck_en) tck = ~tck;
	end
	faes_core i_faes_core (.i_core_clk(clk), .i_srst(srst), .i_ce(ce), .i_addr(addr), .i_rd(rd), .i_wr(wr),
		.i_wdata(wdata), .o_rdata(rdata), .i_e1_mode(e1), .i_esf_mode(esf), .i_crc4_en(crc4),
		.i_alarm_pin_sel(psel), .i_rx_frame_strobe(rxs), .i_rx_mf_start(rxm), .i_rx_crc_mf_start(rxc),
		.i_ts16_data(ts), .i_rx_nonalign_bits(na), .i_tx_frame_strobe(txs), .i_tx_mf_start(txm),
		.i_rx_sync_loss(sync_loss), .i_line_receive_clock_in(rck), .i_line_transmit_clock(tck),
		.i_loop_up_match(loop_up_code_seen), .i_loop_down_match(loop_down_code_seen), .i_spare_match(spr), .o_alarm_pin(alarm), .o_int_n(int_n));
	faes_host i_faes_host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// read a register and compare the bits under a mask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		i_faes_host.rd(a, v);
		chk(nm, exp, v & m);
	endtask
	task automatic rst();
		@(posedge clk);
		#2;
		srst = 1'b1;
		repeat (10) @(posedge clk);
		#2;
		srst = 1'b0;
		fn = 0;
	endtask
	// let n edges pass, then move off the sampling edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// n frames on both sides, frame 0 flagged every per frames
	task automatic frames(input int n, input int per, input logic [7:0] t, input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#2;
			{rxs, txs, ts, na} = {2'b11, t, b};
			{rxm, rxc, txm} = {3{fn == 0}};
			@(posedge clk);
			#2;
			{rxs, txs, rxm, rxc, txm} = 5'h00;
			ts = ~t; // octets are valid only with the strobe
			na = ~b;
			fn = (fn + 1) % per;
			step(3);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rst();
		rchk("alarm_group3_irq_mask reset", FAES_OFS_ALARM_GROUP3_IRQ_MASK, 8'hff, FAES_RST_ALARM_GROUP3_IRQ_MASK);
		rchk("frame_event_irq_mask reset", FAES_OFS_FRAME_EVENT_IRQ_MASK, 8'hff, FAES_RST_FRAME_EVENT_IRQ_MASK);
		rchk("sr4 reset", FAES_OFS_SR4, 8'hff, FAES_RST_SR4);
		i_faes_host.wr(FAES_OFS_FRAME_EVENT_IRQ_MASK, 8'hff);
		rchk("frame_event_irq_mask bit7", FAES_OFS_FRAME_EVENT_IRQ_MASK, 8'hff, 8'h7f);
		i_faes_host.wr(FAES_OFS_ALARM_GROUP3_IRQ_MASK, 8'ha5);
		rchk("alarm_group3_irq_mask rw", FAES_OFS_ALARM_GROUP3_IRQ_MASK, 8'hff, 8'ha5);
		i_faes_host.wr(FAES_OFS_SR4, 8'hff);
		rchk("sr4 ro", FAES_OFS_SR4, 8'hff, 8'h00);
		rchk("unmapped", 8'h55, 8'hff, 8'h00);
	endtask
	// e1 events, latching, distant and remote alarms, interrupt gating
	task automatic t_e1();
		rst();
		{e1, crc4} = 2'b11;
		frames(16, 16, 8'h00, 8'h22);
		chk("int masked", 8'h01, {7'h0, int_n});
		rchk("sr4 zeros mf", FAES_OFS_SR4, 8'hff, 8'h3f);
		rchk("sr4 cleared", FAES_OFS_SR4, 8'hff, 8'h00);
		frames(32, 16, 8'hff, 8'h22);
		rchk("sr4 ones mf", FAES_OFS_SR4, 8'hff, 8'h5f);
		rchk("cond alarms", FAES_OFS_COND, 8'h07, 8'h03);
		i_faes_host.wr(FAES_OFS_ALARM_GROUP3_IRQ_MASK, 8'h01);
		frames(6, 16, 8'hff, 8'h02);
		chk("int fall edge", 8'h00, {7'h0, int_n});
		rchk("rra cleared", FAES_OFS_COND, 8'h01, 8'h00);
		step(3);
		chk("int released", 8'h01, {7'h0, int_n});
		frames(6, 16, 8'hff, 8'h22);
		chk("int rise edge", 8'h00, {7'h0, int_n});
		rchk("rra set", FAES_OFS_COND, 8'h01, 8'h01);
		i_faes_host.wr(FAES_OFS_ALARM_GROUP3_IRQ_MASK, 8'h00);
		rchk("sr4 drain", FAES_OFS_SR4, 8'hff, 8'h1f);
		i_faes_host.wr(FAES_OFS_FRAME_EVENT_IRQ_MASK, 8'h01);
		frames(2, 16, 8'hff, 8'h22);
		chk("int event", 8'h00, {7'h0, int_n});
		rchk("sr4 raf", FAES_OFS_SR4, 8'h01, 8'h01);
		step(3);
		chk("int serviced", 8'h01, {7'h0, int_n});
	endtask
	// line clocks stop while the core is frozen, then a full channel time passes
	task automatic t_clk();
		psel = 1'b1;
		ce = 1'b0;
		{rck_en, tck_en} = 2'b00;
		step(120);
		ce = 1'b1; // idle counters resume from where the freeze left them
		rchk("clock frozen", FAES_OFS_COND, 8'h18, 8'h00);
		step(60);
		rchk("clock early", FAES_OFS_COND, 8'h18, 8'h00);
		step(30);
		rchk("clock loss", FAES_OFS_COND, 8'h18, 8'h18);
		chk("alarm pin tx", 8'h01, {7'h0, alarm});
		{rck_en, tck_en} = 2'b11;
		step(10);
		rchk("clock back", FAES_OFS_COND, 8'h18, 8'h00);
		chk("alarm pin off", 8'h00, {7'h0, alarm});
		psel = 1'b0;
		sync_loss = 1'b1;
		step(4);
		chk("alarm pin sync", 8'h01, {7'h0, alarm});
		sync_loss = 1'b0;
	endtask
	// crc4 off: the crc multiframe event still comes once per 16 frames; sa7 zeros mark the link
	task automatic t_crc_off();
		rst();
		{e1, crc4} = 2'b10;
		frames(16, 16, 8'h00, 8'h00);
		rchk("crc off mf", FAES_OFS_SR4, 8'h02, 8'h02);
		rchk("link seen", FAES_OFS_COND, 8'h07, 8'h04);
	endtask
	// t1 multiframe spacing for d4 and esf, then in-band code flags
	task automatic t_t1();
		logic [7:0] m;
		for (int k = 0; k < 2; k++) begin
			rst();
			{e1, esf} = {1'b0, k == 1};
			frames(1, k ? 24 : 12, 8'h00, 8'h00);
			rchk("t1 mf start", FAES_OFS_SR4, 8'hff, 8'h14);
			frames(k ? 23 : 11, k ? 24 : 12, 8'h00, 8'h00);
			rchk("t1 mid mf", FAES_OFS_SR4, 8'hff, 8'h00);
			frames(1, k ? 24 : 12, 8'h00, 8'h00);
			rchk("t1 mf next", FAES_OFS_SR4, 8'hff, 8'h14);
		end
		for (int k = 0; k < 3; k++) begin
			m = 8'h20 << k;
			{loop_up_code_seen, loop_down_code_seen, spr} = {k == 0, k == 1, k == 2};
			repeat (5) @(posedge clk);
			rchk("code seen", FAES_OFS_COND, 8'he0, m);
			{loop_up_code_seen, loop_down_code_seen, spr} = 3'b000;
			repeat (5) @(posedge clk);
			rchk("code gone", FAES_OFS_COND, 8'he0, 8'h00);
		end
	endtask
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		{srst, e1, esf, crc4, psel, rxs, rxm, rxc, txs, txm, sync_loss} = 11'h400;
		{rck, tck, loop_up_code_seen, loop_down_code_seen, spr, rck_en, tck_en} = 7'h03;
		{ts, na, fail_count, n_compared, fn} = '0;
		ce = 1'b1;
		t_regs();
		t_e1();
		t_clk();
		t_crc_off();
		t_t1();
		final_report();
	end
	// a hang counts as a mismatch
	initial begin
		#2000000;
		fail_count++;
		final_report();
	end
endmodule // faes_core_tb
